// ==== rtl/wdr_map.vh ====
// Purpose: register map, field layout, reset values and timing counts of the watchdog and reset block
// Assumes: 100 MHz system clock, APB with 32-bit data, one aligned word per register
// Notes: definitions only
//
// Overview of operation
// - counter runs on slow oscillator, 2^8..2^18 divide
// - period select picks one of eight overflow counts
// - key 10101 disables, 01010 enables watchdog
// - other key value: delayed reset, fault flag set
// - control powers up at 0x53, watchdog running
// - key fault flag cleared only by writing 0
// - overflow when running: full reset, expired flag set
// - overflow in sleep: flag, clear pc/sp only
// - count cleared by fault, kick, halt, pin
// - kick, halt, bad key, overflow and reset all clear the count
// - reset flag bits 7..4 read zero
// - power-on reset clears program counter to zero
// - power-on sets port data and control ones
// - pin low holds core; release adds delay
// - pin pulse while running restarts from zero
// - supply drop gives full reset like pin
// - sleep entry clears count, runs if enabled
// - halt sets power-down flag, clears expired flag
// - sleep overflow leaves both flags set
`ifndef WDR_MAP_VH
`define WDR_MAP_VH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define WDR_OFS_WATCHDOG_CONTROL 12'h000
`define WDR_OFS_RESET_CAUSE_FLAGS 12'h004
`define WDR_OFS_STATUS 12'h008
`define WDR_OFS_COUNT 12'h00C

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define WDR_KEY_MSB 7
`define WDR_KEY_LSB 3
`define WDR_SEL_MSB 2
`define WDR_SEL_LSB 0
`define WDR_KEY_DISABLE 5'h15
`define WDR_KEY_ENABLE 5'h0A
`define WDR_CONTROL_RST 8'h53
`define WDR_FLAG_PIN_CFG 3
`define WDR_FLAG_SUPPLY_DROP 2
`define WDR_FLAG_SUPPLY_CFG 1
`define WDR_FLAG_KEY_FAULT 0
`define WDR_FLAGS_RST 4'h0
`define WDR_STAT_EXPIRED 0
`define WDR_STAT_POWER_DOWN 1
`define WDR_STAT_CORE_HELD 2
`define WDR_STAT_FAULT_PENDING 3

// --------------------------------------------------------------
// overflow limits (count value minus one) per period select
// --------------------------------------------------------------
`define WDR_LIM_SEL0 18'h000FF
`define WDR_LIM_SEL1 18'h003FF
`define WDR_LIM_SEL2 18'h00FFF
`define WDR_LIM_SEL3 18'h03FFF
`define WDR_LIM_SEL4 18'h07FFF
`define WDR_LIM_SEL5 18'h0FFFF
`define WDR_LIM_SEL6 18'h1FFFF
`define WDR_LIM_SEL7 18'h3FFFF

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define WDR_CLK_PERIOD_NS 10
`define WDR_SOFTWARE_FAULT_DELAY_NS 1000
`define WDR_PIN_RELEASE_DELAY_NS 16000
`define WDR_SOFTWARE_FAULT_DELAY_CYC ((`WDR_SOFTWARE_FAULT_DELAY_NS + `WDR_CLK_PERIOD_NS - 1) / `WDR_CLK_PERIOD_NS)
`define WDR_PIN_RELEASE_DELAY_CYC ((`WDR_PIN_RELEASE_DELAY_NS + `WDR_CLK_PERIOD_NS - 1) / `WDR_CLK_PERIOD_NS)

`endif

// ==== rtl/wdr_sync.v ====
// Purpose: two-stage synchroniser for levels arriving from outside the clock domain
// Assumes: each bit is an independent slow level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps

module wdr_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk_sys,
   input wire rstn,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // --------------------------------------------------------------
   // two flip-flops, reset to a constant
   // --------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rstn) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule // wdr_sync

// ==== rtl/wdr_top.v ====
// Purpose: watchdog timer, keyed control and device reset sequencing behind an APB slave
// Assumes: rstn is the power-on reset; kick and halt are one-cycle pulses from the core
// Notes: slow oscillator, reset pin and supply detector are sampled through synchronisers
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "wdr_map.vh"

module wdr_top (
   input wire clk_sys,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire slow_internal_oscillator,
   input wire external_clear_pin_n,
   input wire pin_function_select,
   input wire supply_drop_detector,
   input wire watchdog_kick_instruction,
   input wire halt_instruction,
   input wire low_power_mode,
   output reg core_reset,
   output reg pc_sp_clear,
   output reg io_ports_init
);

   // --------------------------------------------------------------
   // reset sequencer states
   // --------------------------------------------------------------
   localparam [2:0] ST_RUN = 3'b001;
   localparam [2:0] ST_HOLD = 3'b010;
   localparam [2:0] ST_DELAY = 3'b100;

   // header counts are integer expressions; cut to the counter width on purpose
   localparam integer PIN_DELAY_INT = `WDR_PIN_RELEASE_DELAY_CYC;
   localparam integer SOFT_DELAY_INT = `WDR_SOFTWARE_FAULT_DELAY_CYC;
   localparam [15:0] PIN_DELAY_CYC = PIN_DELAY_INT[15:0];
   localparam [15:0] SOFT_DELAY_CYC = SOFT_DELAY_INT[15:0];

   wire slow_sync;
   wire pin_sync_n;
   wire drop_sync;

   reg slow_prev_reg;
   reg [7:0] control_reg;
   reg [3:0] flags_reg;
   reg expired_reg;
   reg power_down_reg;
   reg [17:0] count_reg;
   reg [17:0] count_next;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [15:0] delay_reg;
   reg [15:0] delay_next;
   reg fault_pending_reg;
   reg [15:0] fault_cnt_reg;
   reg por_seen_reg;
   reg [17:0] limit;
   reg [31:0] rdata_next;
   reg rd_hit;

   wire tick;
   wire [4:0] key;
   wire wdt_enabled;
   wire access_done;
   wire wr_control;
   wire wr_flags;
   wire key_invalid_wr;
   wire fault_expire;
   wire overflow;
   wire ovf_full;
   wire ovf_warm;
   wire pin_low;
   wire hold_src;
   wire pulse_src;
   wire running;

   // --------------------------------------------------------------
   // synchronisers for external levels
   // --------------------------------------------------------------
   wdr_sync #(.WIDTH(3), .INIT(3'b010)) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_in({slow_internal_oscillator, external_clear_pin_n, supply_drop_detector}),
      .sync_out({slow_sync, pin_sync_n, drop_sync})
   );

   // --------------------------------------------------------------
   // decode of control and events
   // --------------------------------------------------------------
   assign tick = slow_sync & ~slow_prev_reg; // one pulse per slow clock period
   assign key = control_reg[`WDR_KEY_MSB:`WDR_KEY_LSB];
   assign wdt_enabled = (key == `WDR_KEY_ENABLE); // 10101 and bad keys stop counting
   assign running = (state_reg == ST_RUN);
   assign access_done = psel & penable & pready;
   assign wr_control = access_done & pwrite & (paddr == `WDR_OFS_WATCHDOG_CONTROL);
   assign wr_flags = access_done & pwrite & (paddr == `WDR_OFS_RESET_CAUSE_FLAGS);
   // every control write is checked for a legal key
   assign key_invalid_wr = wr_control & (pwdata[`WDR_KEY_MSB:`WDR_KEY_LSB] != `WDR_KEY_ENABLE) &
                           (pwdata[`WDR_KEY_MSB:`WDR_KEY_LSB] != `WDR_KEY_DISABLE);
   assign fault_expire = fault_pending_reg & (fault_cnt_reg == 16'h0001);
   assign overflow = running & wdt_enabled & tick & (count_reg == limit);
   assign ovf_full = overflow & ~low_power_mode;
   assign ovf_warm = overflow & low_power_mode;
   // the pin only acts when its reset function is selected
   assign pin_low = pin_function_select & ~pin_sync_n;
   assign hold_src = pin_low | drop_sync;
   assign pulse_src = ovf_full | fault_expire;

   // overflow count per period select
   always @* begin
      case (control_reg[`WDR_SEL_MSB:`WDR_SEL_LSB])
         3'h0: limit = `WDR_LIM_SEL0;
         3'h1: limit = `WDR_LIM_SEL1;
         3'h2: limit = `WDR_LIM_SEL2;
         3'h3: limit = `WDR_LIM_SEL3;
         3'h4: limit = `WDR_LIM_SEL4;
         3'h5: limit = `WDR_LIM_SEL5;
         3'h6: limit = `WDR_LIM_SEL6;
         default: limit = `WDR_LIM_SEL7;
      endcase
   end

   // --------------------------------------------------------------
   // watchdog counter
   // --------------------------------------------------------------
   // clears take priority over counting so a kick never loses to a tick
   always @* begin
      count_next = count_reg;
      if (!running || key_invalid_wr || watchdog_kick_instruction || halt_instruction || overflow) begin
         count_next = 18'h00000;
      end else if (wdt_enabled && tick) begin
         count_next = count_reg + 18'h00001;
      end
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         slow_prev_reg <= 1'b0;
         count_reg <= 18'h00000;
      end else begin
         slow_prev_reg <= slow_sync;
         count_reg <= count_next;
      end
   end

   // --------------------------------------------------------------
   // software fault delay after a bad key
   // --------------------------------------------------------------
   // a second bad write while pending does not restart the delay
   always @(posedge clk_sys) begin
      if (!rstn) begin
         fault_pending_reg <= 1'b0;
         fault_cnt_reg <= 16'h0000;
      end else if (fault_expire || !running) begin
         fault_pending_reg <= 1'b0;
         fault_cnt_reg <= 16'h0000;
      end else if (key_invalid_wr && !fault_pending_reg) begin
         fault_pending_reg <= 1'b1;
         fault_cnt_reg <= SOFT_DELAY_CYC;
      end else if (fault_pending_reg) begin
         fault_cnt_reg <= fault_cnt_reg - 16'h0001;
      end
   end

   // --------------------------------------------------------------
   // reset sequencer
   // --------------------------------------------------------------
   // level sources hold the core; every source ends in the release delay
   always @* begin
      state_next = state_reg;
      delay_next = delay_reg;
      case (state_reg)
         ST_RUN: begin
            if (hold_src) begin
               state_next = ST_HOLD;
            end else if (pulse_src) begin
               state_next = ST_DELAY;
               delay_next = PIN_DELAY_CYC;
            end
         end
         ST_HOLD: begin
            if (!hold_src) begin
               state_next = ST_DELAY;
               delay_next = PIN_DELAY_CYC;
            end
         end
         ST_DELAY: begin
            if (hold_src) begin
               state_next = ST_HOLD;
            end else if (delay_reg <= 16'h0001) begin
               state_next = ST_RUN;
               delay_next = 16'h0000;
            end else begin
               delay_next = delay_reg - 16'h0001;
            end
         end
         default: begin
            state_next = ST_DELAY;
            delay_next = PIN_DELAY_CYC;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= ST_DELAY;
         delay_reg <= PIN_DELAY_CYC;
         por_seen_reg <= 1'b0;
         core_reset <= 1'b1;
         pc_sp_clear <= 1'b1;
         io_ports_init <= 1'b1;
      end else begin
         state_reg <= state_next;
         delay_reg <= delay_next;
         if (state_next == ST_RUN) begin
            por_seen_reg <= 1'b1;
         end
         core_reset <= (state_next != ST_RUN);
         // pc restarts from zero after every reset, warm or full
         pc_sp_clear <= (state_next != ST_RUN) | ovf_warm;
         io_ports_init <= ~por_seen_reg & (state_next != ST_RUN);
      end
   end

   // --------------------------------------------------------------
   // control register and flags
   // --------------------------------------------------------------
   // a full reset restores the control register; warm reset leaves it
   always @(posedge clk_sys) begin
      if (!rstn) begin
         control_reg <= `WDR_CONTROL_RST;
      end else if (pulse_src || hold_src) begin
         control_reg <= `WDR_CONTROL_RST;
      end else if (wr_control) begin
         control_reg <= pwdata[7:0];
      end
   end

   // hardware set wins over a software clear in the same cycle
   always @(posedge clk_sys) begin
      if (!rstn) begin
         flags_reg <= `WDR_FLAGS_RST;
      end else begin
         if (wr_flags) begin
            flags_reg <= flags_reg & pwdata[3:0]; // only a 0 clears
         end
         if (fault_expire) begin
            flags_reg[`WDR_FLAG_KEY_FAULT] <= 1'b1;
         end
         if (drop_sync) begin
            flags_reg[`WDR_FLAG_SUPPLY_DROP] <= 1'b1;
         end
         flags_reg[`WDR_FLAG_PIN_CFG] <= 1'b0;
         flags_reg[`WDR_FLAG_SUPPLY_CFG] <= 1'b0;
      end
   end

   // expired and power-down flags; overflow wins over halt clearing
   always @(posedge clk_sys) begin
      if (!rstn) begin
         expired_reg <= 1'b0;
         power_down_reg <= 1'b0;
      end else begin
         if (overflow) begin
            expired_reg <= 1'b1;
         end else if (halt_instruction) begin
            expired_reg <= 1'b0;
         end
         if (halt_instruction) begin
            power_down_reg <= 1'b1;
         end else if (watchdog_kick_instruction) begin
            power_down_reg <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // APB slave: data captured in setup, one wait state
   // --------------------------------------------------------------
   always @* begin
      rdata_next = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr)
         `WDR_OFS_WATCHDOG_CONTROL: rdata_next[7:0] = control_reg;
         `WDR_OFS_RESET_CAUSE_FLAGS: rdata_next[3:0] = flags_reg; // upper bits zero
         `WDR_OFS_STATUS: begin
            rdata_next[`WDR_STAT_EXPIRED] = expired_reg;
            rdata_next[`WDR_STAT_POWER_DOWN] = power_down_reg;
            rdata_next[`WDR_STAT_CORE_HELD] = ~running;
            rdata_next[`WDR_STAT_FAULT_PENDING] = fault_pending_reg;
         end
         `WDR_OFS_COUNT: rdata_next[17:0] = count_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rdata_next;
            pslverr <= ~rd_hit;
         end
         pready <= psel & penable & ~pready;
      end
   end

endmodule // wdr_top

// ==== sim/wdr_monitor.sv ====
// Purpose: port-level assertions for the watchdog and reset block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to wdr_top; sees only its ports
`timescale 1ns/1ps
module wdr_monitor (
   input wire clk_sys,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire external_clear_pin_n,
   input wire pin_function_select,
   input wire supply_drop_detector,
   input wire low_power_mode,
   input wire core_reset,
   input wire pc_sp_clear,
   input wire io_ports_init
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   reg [10:0] hold_cnt_reg;
   // ------------------------------
   // helper logic and sequences
   // ------------------------------
   // cycles the core has been held; saturates so a long hold never wraps
   always @(posedge clk_sys) begin
      if (!rstn || !core_reset) begin
         hold_cnt_reg <= 11'h000;
      end else if (hold_cnt_reg != 11'h7FF) begin
         hold_cnt_reg <= hold_cnt_reg + 11'h001;
      end
   end
   sequence apb_setup; psel && !penable; endsequence
   sequence apb_wait; !pready ##1 pready; endsequence
   sequence pin_low; pin_function_select && !external_clear_pin_n; endsequence
   sequence bad_key_wr;
      psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[7:3] != 5'h15 && pwdata[7:3] != 5'h0A;
   endsequence
   // ------------------------------
   // assertions
   // ------------------------------
   one_wait_a: assert property (apb_setup |=> apb_wait) else $error("pready not after one wait state");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   unmapped_err_a: assert property (pready |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'b00))
      else $error("pslverr wrong");
   start_out_a: assert property ($rose(rstn) |-> core_reset && pc_sp_clear && io_ports_init)
      else $error("reset outputs not high after power-on");
   io_init_hold_a: assert property (io_ports_init |-> core_reset) else $error("port init outside reset");
   held_pc_a: assert property (core_reset |-> pc_sp_clear) else $error("pc not cleared while held");
   release_delay_a: assert property ($fell(core_reset) |-> hold_cnt_reg >= 11'h63F)
      else $error("core released too early");
   pin_hold_a: assert property (pin_low [*5] |-> core_reset) else $error("pin low did not hold core");
   supply_hold_a: assert property (supply_drop_detector [*5] |-> core_reset)
      else $error("supply drop did not hold core");
   warm_pulse_a: assert property ($rose(pc_sp_clear) && !core_reset |-> low_power_mode ##1 !pc_sp_clear && !core_reset)
      else $error("warm clear not a single pulse");
   fault_delay_a: assert property (bad_key_wr |-> ##[95:105] core_reset)
      else $error("bad key reset not after delay");
endmodule // wdr_monitor

bind wdr_top wdr_monitor i_mon (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .external_clear_pin_n(external_clear_pin_n),
   .pin_function_select(pin_function_select), .supply_drop_detector(supply_drop_detector),
   .low_power_mode(low_power_mode), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear), .io_ports_init(io_ports_init));

// ==== sim/tb_watchdog_and_reset_control.sv ====
// Purpose: self-checking bench for the watchdog and reset block
// Assumes: oscillator made fast (8 clocks a tick) so overflows fit the run
// Notes: registers reached only through APB tasks
`timescale 1ns/1ps
`include "wdr_map.vh"
`define CHK(nm, e, g) begin checks = checks + 1; if ((g) !== (e)) begin err_count = err_count + 1; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_watchdog_and_reset_control;
   reg clk_sys, rstn, psel, penable, pwrite, ext_n, pin_sel, drop, kick, halt, low_pwr;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd, c1;
   reg [2:0] osc_div;
   reg er;
   wire [31:0] prdata;
   wire pready, pslverr, core_reset, pc_sp_clear, io_ports_init;
   integer err_count, checks, cyc, k;
   wdr_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_internal_oscillator(osc_div[2]),
      .external_clear_pin_n(ext_n), .pin_function_select(pin_sel), .supply_drop_detector(drop),
      .watchdog_kick_instruction(kick), .halt_instruction(halt), .low_power_mode(low_pwr),
      .core_reset(core_reset), .pc_sp_clear(pc_sp_clear), .io_ports_init(io_ports_init));
   // ------------------------------
   // clock, oscillator and hang guard
   // ------------------------------
   always #5 clk_sys = ~clk_sys;
   // oscillator tick every 8 clocks keeps a 2^8 overflow near 2048 cycles
   always @(posedge clk_sys) begin
      osc_div <= osc_div + 3'h1;
      cyc = cyc + 1;
      if (cyc == 30000) begin
         err_count = err_count + 1;
         wrap_up;
      end
   end
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", checks, err_count);
         if (err_count == 0 && checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // ------------------------------
   // bus and wait helpers
   // ------------------------------
   // request held until pready is seen high, then released
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_sys); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge clk_sys); penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1) @(posedge clk_sys);
         rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
      end
   endtask
   task pulse(input h);
      begin
         @(posedge clk_sys); if (h) halt <= 1'b1; else kick <= 1'b1;
         @(posedge clk_sys); halt <= 1'b0; kick <= 1'b0;
      end
   endtask
   // bounded wait for core_reset (s=0) or pc_sp_clear (s=1) to reach v
   task wait_on(input s, input v, input integer n);
      begin
         k = 0;
         while (k < n && (s ? pc_sp_clear : core_reset) !== v) begin @(posedge clk_sys); #1; k = k + 1; end
      end
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task t_start;
      begin
         wait_on(0, 0, 1700); `CHK("start delay", 1'b1, k > 1590)
         apb(0, `WDR_OFS_WATCHDOG_CONTROL, 0); `CHK("control", 32'h00000053, rd)
         apb(0, `WDR_OFS_RESET_CAUSE_FLAGS, 0); `CHK("flags", 32'h00000000, rd)
         apb(1, 12'h010, 32'hFFFFFFFF); `CHK("unmapped err", 1'b1, er)
         apb(0, 12'h010, 0); `CHK("unmapped data", 32'h00000000, rd)
      end
   endtask
   task t_badkey;
      begin
         apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h00000003); wait_on(0, 1, 120);
         `CHK("fault delay", 1'b1, k >= 95 && core_reset === 1'b1)
         `CHK("no port init", 1'b0, io_ports_init)
         wait_on(0, 0, 1700);
         apb(1, `WDR_OFS_RESET_CAUSE_FLAGS, 32'h000000FF);
         apb(0, `WDR_OFS_RESET_CAUSE_FLAGS, 0); `CHK("key fault flag", 32'h00000001, rd)
         apb(1, `WDR_OFS_RESET_CAUSE_FLAGS, 0);
         apb(0, `WDR_OFS_RESET_CAUSE_FLAGS, 0); `CHK("flag cleared", 32'h00000000, rd)
         apb(0, `WDR_OFS_WATCHDOG_CONTROL, 0); `CHK("control back", 32'h00000053, rd)
      end
   endtask
   task t_disable;
      begin
         apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h000000AB); apb(0, `WDR_OFS_COUNT, 0); c1 = rd; repeat (100) @(posedge clk_sys);
         apb(0, `WDR_OFS_COUNT, 0); `CHK("held count", c1, rd)
         pulse(0); apb(0, `WDR_OFS_COUNT, 0); `CHK("kicked count", 32'h00000000, rd)
         apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h00000053);
      end
   endtask
   task t_overflow;
      begin
         pulse(0); apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h00000050); wait_on(0, 1, 2400);
         `CHK("overflow time", 1'b1, k > 1900 && core_reset === 1'b1)
         wait_on(0, 0, 1700); apb(0, `WDR_OFS_STATUS, 0); `CHK("expired", 1'b1, rd[0])
         apb(0, `WDR_OFS_WATCHDOG_CONTROL, 0); `CHK("control restored", 32'h00000053, rd)
      end
   endtask
   task t_sleep;
      begin
         low_pwr <= 1'b1; pulse(0); apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h00000050); pulse(1);
         apb(0, `WDR_OFS_COUNT, 0); `CHK("halt count", 1'b1, rd < 2)
         apb(0, `WDR_OFS_STATUS, 0); `CHK("halt flags", 2'b10, rd[1:0])
         wait_on(1, 1, 2400); `CHK("sleep overflow", 1'b1, k > 1900 && core_reset === 1'b0)
         repeat (2) @(posedge clk_sys); #1; `CHK("warm pulse", 1'b0, pc_sp_clear)
         apb(0, `WDR_OFS_STATUS, 0); `CHK("sleep flags", 2'b11, rd[1:0])
         low_pwr <= 1'b0; pulse(0); apb(1, `WDR_OFS_WATCHDOG_CONTROL, 32'h00000053);
      end
   endtask
   task t_pin_supply;
      begin
         @(posedge clk_sys); pin_sel <= 1'b1; ext_n <= 1'b0; repeat (20) @(posedge clk_sys); #1;
         `CHK("pin hold", 1'b1, core_reset)
         @(posedge clk_sys); ext_n <= 1'b1; wait_on(0, 0, 1700); `CHK("pin delay", 1'b1, k > 1590)
         @(posedge clk_sys); pin_sel <= 1'b0; drop <= 1'b1; repeat (20) @(posedge clk_sys); #1;
         `CHK("drop hold", 1'b1, core_reset)
         @(posedge clk_sys); drop <= 1'b0; wait_on(0, 0, 1700);
         apb(0, `WDR_OFS_RESET_CAUSE_FLAGS, 0); `CHK("drop flag", 32'h00000004, rd)
      end
   endtask
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      clk_sys = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; osc_div = 0;
      ext_n = 1; pin_sel = 0; drop = 0; kick = 0; halt = 0; low_pwr = 0; err_count = 0; checks = 0; cyc = 0;
      repeat (3) @(posedge clk_sys); #1;
      `CHK("port init", 1'b1, io_ports_init)
      `CHK("pc clear", 1'b1, pc_sp_clear)
      @(posedge clk_sys); rstn <= 1'b1;
      t_start; t_badkey; t_disable; t_overflow; t_sleep; t_pin_supply;
      wrap_up;
   end
endmodule // tb_watchdog_and_reset_control
